// >>> logic/atfpc_pkg.sv
/*
  package for the asynchronous-capable 8-bit timer flag, clock and prescaler block:
  register offsets, field positions, reset values and mode encodings.
  assumes a byte-wide data-space register port and one clock.
*/
package atfpc_pkg;

  localparam int unsigned DW = 8;
  localparam int unsigned AW = 8;

  // data-space offsets
  localparam logic [AW-1:0] OFF_FLAGS  = 8'h37;
  localparam logic [AW-1:0] OFF_SYNC   = 8'h43;
  localparam logic [AW-1:0] OFF_MASK   = 8'h70;
  localparam logic [AW-1:0] OFF_CTRL_A = 8'hB0;
  localparam logic [AW-1:0] OFF_CTRL_B = 8'hB1;
  localparam logic [AW-1:0] OFF_COUNT  = 8'hB2;
  localparam logic [AW-1:0] OFF_CMP_A  = 8'hB3;
  localparam logic [AW-1:0] OFF_CMP_B  = 8'hB4;
  localparam logic [AW-1:0] OFF_STATUS = 8'hB6;

  localparam logic [DW-1:0] RST_BYTE = 8'h00;
  localparam logic [DW-1:0] MAX_CNT  = 8'hFF;
  localparam logic [DW-1:0] BOTTOM   = 8'h00;

  // timer_event_flags / interrupt mask fields
  localparam int unsigned B_OVF   = 0;
  localparam int unsigned B_CMP_A = 1;
  // async_clock_status fields
  localparam int unsigned B_EXT_CLK  = 6;
  localparam int unsigned B_ASYNC    = 5;
  localparam int unsigned B_BUSY_TOP = 4;
  // general_timer_sync_control fields
  localparam int unsigned B_HOLD     = 7;
  localparam int unsigned B_PSR_ASY  = 1;
  localparam int unsigned B_PSR_SYNC = 0;
  // timer_control_a / timer_control_b fields
  localparam int unsigned B_WGM_LO  = 0;
  localparam int unsigned B_WGM_HI  = 3;
  localparam int unsigned CS_MSB    = 2;

  // busy-slot order, matching status bits 4..0
  localparam int unsigned NSLOT   = 5;
  localparam int unsigned S_CTL_B = 0;
  localparam int unsigned S_CTL_A = 1;
  localparam int unsigned S_CMP_B = 2;
  localparam int unsigned S_CMP_A = 3;
  localparam int unsigned S_COUNT = 4;

  localparam int unsigned PSC_W = 10;

  // waveform modes
  localparam logic [2:0] WGM_PC_MAX  = 3'h1;
  localparam logic [2:0] WGM_CTC     = 3'h2;
  localparam logic [2:0] WGM_PC_CMP  = 3'h5;
  localparam logic [2:0] WGM_FAST_CMP = 3'h7;

  typedef enum logic {DIR_UP, DIR_DOWN} atfpc_dir_t;

endpackage : atfpc_pkg

// >>> logic/atfpc_prescaler.sv
/*
  prescaler: ten-bit divider of a source tick, with tap select per clock-select code.
  assumes src_tick_i is a one-cycle pulse in the ref_clk_i domain.
*/
`timescale 1ns/100ps
module atfpc_prescaler
  import atfpc_pkg::*;
(
  input  wire logic            ref_clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            clear_i,
  input  wire logic            src_tick_i,
  input  wire logic [CS_MSB:0] sel_i,
  output logic                 tick_o
);

  logic [PSC_W-1:0] cnt_ff;
  logic [PSC_W-1:0] nxt_cnt;
  logic             hit;

  // low bits that must be all ones for a divided tick
  function automatic logic [PSC_W-1:0] tap_mask(input logic [CS_MSB:0] s);
    unique case (s)
      3'h2:    tap_mask = 10'h007;
      3'h3:    tap_mask = 10'h01F;
      3'h4:    tap_mask = 10'h03F;
      3'h5:    tap_mask = 10'h07F;
      3'h6:    tap_mask = 10'h0FF;
      3'h7:    tap_mask = 10'h3FF;
      default: tap_mask = 10'h000;
    endcase
  endfunction : tap_mask

  assign hit     = (cnt_ff & tap_mask(sel_i)) == tap_mask(sel_i);
  assign nxt_cnt = clear_i ? '0 : (src_tick_i ? cnt_ff + 1'b1 : cnt_ff);
  assign tick_o  = src_tick_i & ~clear_i & (sel_i != 3'h0) & hit;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : atfpc_prescaler

// >>> logic/atfpc_busy_slot.sv
/*
  one timer register with temporary storage and an update-busy bit.
  assumes xfer_i marks an oscillator edge when async_i is high.
*/
`timescale 1ns/100ps
module atfpc_busy_slot
  import atfpc_pkg::*;
(
  input  wire logic          ref_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          async_i,
  input  wire logic          xfer_i,
  input  wire logic          wr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0]      data_o,
  output logic               busy_o,
  output logic               load_o
);

  logic [DW-1:0] temp_ff;
  logic [DW-1:0] data_ff;
  logic          busy_ff;
  logic          load_ff;
  logic          direct;
  logic          commit;

  assign direct = wr_i & ~async_i;
  assign commit = busy_ff & xfer_i;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      temp_ff <= RST_BYTE;
      data_ff <= RST_BYTE;
      busy_ff <= 1'b0;
      load_ff <= 1'b0;
    end else begin
      if (wr_i) begin
        temp_ff <= wdata_i;
      end
      if (direct) begin
        data_ff <= wdata_i;
      end else if (commit) begin
        data_ff <= temp_ff;
      end
      busy_ff <= (wr_i & async_i) | (busy_ff & ~xfer_i & async_i); // RULE12
      load_ff <= direct | commit;
    end
  end

  assign data_o = data_ff;
  assign busy_o = busy_ff;
  assign load_o = load_ff;

endmodule : atfpc_busy_slot

// >>> logic/atfpc_timer.sv
/*
  status and control of an 8-bit timer that can run from the I/O clock or from an
  oscillator pin: event flags, interrupt requests, clock-source select, update-busy
  tracking and the shared prescaler-reset/synchronisation control, with a small counter.
  assumes a byte-wide data-space port with write strobe, read data one cycle after the
  address, and an oscillator pin sampled synchronously to ref_clk_i.

// How it works
// [RULE1] compare-A flag, bit 1, sets when counter equals compare A
// [RULE2] compare-A flag clears on vector execution or written one
// [RULE3] compare-A request needs global enable, its enable and its flag
// [RULE4] overflow flag, bit 0, sets when the counter overflows
// [RULE5] overflow flag clears on vector execution or written one
// [RULE6] overflow request needs global enable, its enable and its flag
// [RULE7] phase-correct modes set overflow when direction turns at zero
// [RULE8] external-clock bit with async enables input buffer; crystal runs only when clear
// [RULE9] software writes external-clock bit before selecting async clocking
// [RULE10] async-select zero clocks from I/O clock, one from oscillator pin
// [RULE11] software rewrites timer registers after changing async select
// [RULE12] async writes set per-register busy bits, cleared after transfer
// [RULE13] software never writes a timer register while its busy bit is set
// [RULE14] synchronisation mode keeps both prescaler-reset bits as written
// [RULE15] writing synchronisation mode zero clears both prescaler-reset bits
// [RULE16] async prescaler reset self-clears, waits in async mode, holds in sync mode
// [RULE17] shared prescaler reset self-clears at once except in sync mode
// [RULE18] counter write suppresses compare match on the next timer clock
// [RULE19] written zeros leave flags alone; flags read back their state
*/
`timescale 1ns/100ps
module atfpc_timer
  import atfpc_pkg::*;
(
  input  wire logic          ref_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          we_i,
  output logic [DW-1:0]      rdata_o,
  input  wire logic          global_irq_en_i,
  input  wire logic          cmp_a_vec_ack_i,
  input  wire logic          ovf_vec_ack_i,
  input  wire logic          osc_input_pin_i,
  output logic               cmp_a_irq_o,
  output logic               ovf_irq_o,
  output logic               ext_buf_en_o,
  output logic               xtal_run_o,
  output logic               shared_prescaler_reset_o,
  output logic [DW-1:0]      counter_value_o
);

  //////////////////////////////////////////////////////////////////////////////
  // register decode

  function automatic logic reg_hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  logic wr_flags;
  logic wr_sync;
  logic wr_mask;
  logic wr_status;
  logic [NSLOT-1:0] wr_slot;

  assign wr_flags  = we_i & reg_hit(addr_i, OFF_FLAGS);
  assign wr_sync   = we_i & reg_hit(addr_i, OFF_SYNC);
  assign wr_mask   = we_i & reg_hit(addr_i, OFF_MASK);
  assign wr_status = we_i & reg_hit(addr_i, OFF_STATUS);
  assign wr_slot[S_COUNT] = we_i & reg_hit(addr_i, OFF_COUNT);
  assign wr_slot[S_CMP_A] = we_i & reg_hit(addr_i, OFF_CMP_A);
  assign wr_slot[S_CMP_B] = we_i & reg_hit(addr_i, OFF_CMP_B);
  assign wr_slot[S_CTL_A] = we_i & reg_hit(addr_i, OFF_CTRL_A);
  assign wr_slot[S_CTL_B] = we_i & reg_hit(addr_i, OFF_CTRL_B);

  //////////////////////////////////////////////////////////////////////////////
  // clock source and async status

  logic ext_clk_ff;
  logic async_ff;
  logic osc_q_ff;
  logic osc_edge;
  logic src_tick;
  logic xfer;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ext_clk_ff <= 1'b0;
      async_ff   <= 1'b0;
      osc_q_ff   <= 1'b0;
    end else begin
      if (wr_status) begin
        ext_clk_ff <= wdata_i[B_EXT_CLK];
        async_ff   <= wdata_i[B_ASYNC];
      end
      osc_q_ff <= osc_input_pin_i;
    end
  end

  assign osc_edge = osc_input_pin_i & ~osc_q_ff;
  assign src_tick = async_ff ? osc_edge : 1'b1; // RULE10
  assign xfer     = async_ff & osc_edge;

  //////////////////////////////////////////////////////////////////////////////
  // timer registers behind temporary storage

  logic [DW-1:0]    slot_data [NSLOT];
  logic [NSLOT-1:0] slot_busy;
  logic [NSLOT-1:0] slot_load;

  genvar gi;
  generate
    for (gi = 0; gi < NSLOT; gi++) begin : g_slot
      atfpc_busy_slot u_slot (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (async_ff),
        .xfer_i    (xfer),
        .wr_i      (wr_slot[gi]),
        .wdata_i   (wdata_i),
        .data_o    (slot_data[gi]),
        .busy_o    (slot_busy[gi]),
        .load_o    (slot_load[gi])
      );
    end
  endgenerate

  logic [DW-1:0] cmp_a;
  logic [DW-1:0] ctl_a;
  logic [DW-1:0] ctl_b;
  logic [2:0]    wgm;
  logic          phase_mode;
  logic          ctc_mode;
  logic [DW-1:0] top;

  assign cmp_a      = slot_data[S_CMP_A];
  assign ctl_a      = slot_data[S_CTL_A];
  assign ctl_b      = slot_data[S_CTL_B];
  assign wgm        = {ctl_b[B_WGM_HI], ctl_a[B_WGM_LO+1], ctl_a[B_WGM_LO]};
  assign phase_mode = (wgm == WGM_PC_MAX) | (wgm == WGM_PC_CMP);
  assign ctc_mode   = (wgm == WGM_CTC);
  assign top        = (wgm == WGM_PC_CMP || wgm == WGM_FAST_CMP || ctc_mode) ? cmp_a : MAX_CNT;

  //////////////////////////////////////////////////////////////////////////////
  // prescaler reset and synchronisation control

  logic hold_ff;
  logic psr_asy_ff;
  logic psr_sync_ff;
  logic nxt_hold;
  logic nxt_psr_asy;
  logic nxt_psr_sync;
  logic asy_done;

  // an async reset is complete at once on the I/O clock, else once an oscillator edge has passed with it applied
  assign asy_done = ~async_ff | osc_edge;

  always_comb begin
    nxt_hold     = hold_ff;
    nxt_psr_asy  = psr_asy_ff;
    nxt_psr_sync = psr_sync_ff;
    if (wr_sync) begin
      nxt_hold     = wdata_i[B_HOLD];
      nxt_psr_asy  = wdata_i[B_PSR_ASY];
      nxt_psr_sync = wdata_i[B_PSR_SYNC];
    end else if (!hold_ff) begin
      nxt_psr_sync = 1'b0; // RULE17
      if (asy_done) begin
        nxt_psr_asy = 1'b0; // RULE16
      end
    end
    if (wr_sync && !wdata_i[B_HOLD] && hold_ff) begin
      nxt_psr_asy  = 1'b0; // RULE15
      nxt_psr_sync = 1'b0; // RULE15
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      hold_ff     <= 1'b0;
      psr_asy_ff  <= 1'b0;
      psr_sync_ff <= 1'b0;
    end else begin
      hold_ff     <= nxt_hold;
      psr_asy_ff  <= nxt_psr_asy; // RULE14
      psr_sync_ff <= nxt_psr_sync; // RULE14
    end
  end

  logic tmr_tick;

  atfpc_prescaler u_psc (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .clear_i    (psr_asy_ff),
    .src_tick_i (src_tick),
    .sel_i      (ctl_b[CS_MSB:0]),
    .tick_o     (tmr_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // counter, match and overflow events

  atfpc_dir_t    dir_ff;
  atfpc_dir_t    nxt_dir;
  logic [DW-1:0] cnt_ff;
  logic [DW-1:0] nxt_cnt;
  logic          block_ff;
  logic          match_ev;
  logic          ovf_ev;

  assign match_ev = tmr_tick & ~block_ff & (cnt_ff == cmp_a); // RULE1 RULE18

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_dir = dir_ff;
    ovf_ev  = 1'b0;
    if (tmr_tick) begin
      if (phase_mode) begin
        unique case (dir_ff)
          DIR_UP: begin
            if (cnt_ff == top) begin
              nxt_dir = DIR_DOWN;
              nxt_cnt = cnt_ff - 1'b1;
            end else begin
              nxt_cnt = cnt_ff + 1'b1;
            end
          end
          DIR_DOWN: begin
            if (cnt_ff == BOTTOM) begin
              nxt_dir = DIR_UP;
              nxt_cnt = cnt_ff + 1'b1;
              ovf_ev  = 1'b1; // RULE7
            end else begin
              nxt_cnt = cnt_ff - 1'b1;
            end
          end
        endcase
      end else begin
        nxt_dir = DIR_UP;
        if (cnt_ff == MAX_CNT) begin
          ovf_ev  = 1'b1; // RULE4
          nxt_cnt = BOTTOM;
        end else if (cnt_ff == top) begin
          nxt_cnt = BOTTOM;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
    end
    if (slot_load[S_COUNT]) begin
      nxt_cnt = slot_data[S_COUNT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt_ff   <= RST_BYTE;
      dir_ff   <= DIR_UP;
      block_ff <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      dir_ff   <= nxt_dir;
      block_ff <= slot_load[S_COUNT] | (block_ff & ~tmr_tick); // RULE18
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flags, mask and interrupt requests

  logic cmp_a_match_flag_ff;
  logic overflow_flag_ff;
  logic cmp_a_irq_enable_ff;
  logic overflow_irq_enable_ff;
  logic nxt_cmp_a_flag;
  logic nxt_ovf_flag;
  logic nxt_cmp_a_en;
  logic nxt_ovf_en;
  logic clr_cmp_a;
  logic clr_ovf;

  // requests follow a mask write in the same cycle as the enable register
  assign nxt_cmp_a_en = wr_mask ? wdata_i[B_CMP_A] : cmp_a_irq_enable_ff;
  assign nxt_ovf_en   = wr_mask ? wdata_i[B_OVF] : overflow_irq_enable_ff;

  assign clr_cmp_a = cmp_a_vec_ack_i | (wr_flags & wdata_i[B_CMP_A]); // RULE2 RULE19
  assign clr_ovf   = ovf_vec_ack_i | (wr_flags & wdata_i[B_OVF]); // RULE5 RULE19
  // a set in the clearing cycle wins
  assign nxt_cmp_a_flag = match_ev | (cmp_a_match_flag_ff & ~clr_cmp_a); // RULE1
  assign nxt_ovf_flag   = ovf_ev | (overflow_flag_ff & ~clr_ovf); // RULE4

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cmp_a_match_flag_ff    <= 1'b0;
      overflow_flag_ff       <= 1'b0;
      cmp_a_irq_enable_ff    <= 1'b0;
      overflow_irq_enable_ff <= 1'b0;
    end else begin
      cmp_a_match_flag_ff <= nxt_cmp_a_flag;
      overflow_flag_ff    <= nxt_ovf_flag;
      cmp_a_irq_enable_ff    <= nxt_cmp_a_en;
      overflow_irq_enable_ff <= nxt_ovf_en;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs and read data

  logic [DW-1:0] rd_mux;
  logic [DW-1:0] flags_rd;
  logic [DW-1:0] mask_rd;
  logic [DW-1:0] status_rd;
  logic [DW-1:0] sync_rd;

  always_comb begin
    flags_rd = RST_BYTE;
    flags_rd[B_CMP_A] = cmp_a_match_flag_ff; // RULE19
    flags_rd[B_OVF]   = overflow_flag_ff;
    mask_rd = RST_BYTE;
    mask_rd[B_CMP_A] = cmp_a_irq_enable_ff;
    mask_rd[B_OVF]   = overflow_irq_enable_ff;
    status_rd = RST_BYTE;
    status_rd[B_EXT_CLK] = ext_clk_ff;
    status_rd[B_ASYNC]   = async_ff;
    status_rd[B_BUSY_TOP:0] = slot_busy; // RULE12
    sync_rd = RST_BYTE;
    sync_rd[B_HOLD]     = hold_ff;
    sync_rd[B_PSR_ASY]  = psr_asy_ff;
    sync_rd[B_PSR_SYNC] = psr_sync_ff;
  end

  assign rd_mux = reg_hit(addr_i, OFF_FLAGS)  ? flags_rd  :
                  reg_hit(addr_i, OFF_MASK)   ? mask_rd   :
                  reg_hit(addr_i, OFF_STATUS) ? status_rd :
                  reg_hit(addr_i, OFF_SYNC)   ? sync_rd   :
                  reg_hit(addr_i, OFF_COUNT)  ? cnt_ff    :
                  reg_hit(addr_i, OFF_CMP_A)  ? cmp_a     :
                  reg_hit(addr_i, OFF_CMP_B)  ? slot_data[S_CMP_B] :
                  reg_hit(addr_i, OFF_CTRL_A) ? ctl_a     :
                  reg_hit(addr_i, OFF_CTRL_B) ? ctl_b     : RST_BYTE;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_o                  <= RST_BYTE;
      cmp_a_irq_o              <= 1'b0;
      ovf_irq_o                <= 1'b0;
      ext_buf_en_o             <= 1'b0;
      xtal_run_o               <= 1'b0;
      shared_prescaler_reset_o <= 1'b0;
      counter_value_o          <= RST_BYTE;
    end else begin
      rdata_o      <= rd_mux;
      cmp_a_irq_o  <= global_irq_en_i & nxt_cmp_a_en & nxt_cmp_a_flag; // RULE3
      ovf_irq_o    <= global_irq_en_i & nxt_ovf_en & nxt_ovf_flag; // RULE6
      ext_buf_en_o <= ext_clk_ff & async_ff; // RULE8
      xtal_run_o   <= async_ff & ~ext_clk_ff; // RULE8
      shared_prescaler_reset_o <= nxt_psr_sync; // RULE17
      counter_value_o          <= nxt_cnt;
    end
  end

endmodule : atfpc_timer

// >>> bench/atfpc_checker.sv
/*
  port-level assertions for atfpc_timer: interrupt gating, clock-source outputs,
  prescaler-reset hold and release, unmapped reads.
  assumes it is bound to every atfpc_timer instance by the bind below.
*/
`timescale 1ns/100ps
module atfpc_checker
  import atfpc_pkg::*;
(
  input wire logic          ref_clk_i,
  input wire logic          rst_n_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic          we_i,
  input wire logic [DW-1:0] rdata_o,
  input wire logic          global_irq_en_i,
  input wire logic          cmp_a_irq_o,
  input wire logic          ovf_irq_o,
  input wire logic          ext_buf_en_o,
  input wire logic          xtal_run_o,
  input wire logic          shared_prescaler_reset_o
);
  logic hold_ff;
  logic nxt_hold;
  wire  sync_wr  = we_i && (addr_i == OFF_SYNC);
  wire  stat_wr  = we_i && (addr_i == OFF_STATUS);
  wire  mapped_a = addr_i inside {OFF_FLAGS, OFF_SYNC, OFF_MASK, OFF_CTRL_A, OFF_CTRL_B,
                                  OFF_COUNT, OFF_CMP_A, OFF_CMP_B, OFF_STATUS};
  // software view of the synchronisation-mode bit
  assign nxt_hold = sync_wr ? wdata_i[B_HOLD] : hold_ff;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) hold_ff <= 1'b0;
    else hold_ff <= nxt_hold;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////
  chk_buf_xtal_excl: assert property (!(ext_buf_en_o && xtal_run_o))
    else $error("ext buffer and crystal both on");
  chk_ext_buf_on: assert property (stat_wr && wdata_i[B_EXT_CLK] && wdata_i[B_ASYNC]
    |-> ##[1:2] ext_buf_en_o) else $error("ext buffer not enabled");
  chk_xtal_runs: assert property (stat_wr && !wdata_i[B_EXT_CLK] && wdata_i[B_ASYNC]
    |-> ##[1:2] xtal_run_o) else $error("crystal not running");
  chk_cmp_gie: assert property (cmp_a_irq_o |-> $past(global_irq_en_i))
    else $error("compare request without global enable");
  chk_ovf_gie: assert property (ovf_irq_o |-> $past(global_irq_en_i))
    else $error("overflow request without global enable");
  chk_hold_keeps: assert property (shared_prescaler_reset_o && hold_ff && !sync_wr
    && !$past(sync_wr) |=> shared_prescaler_reset_o) else $error("held reset released");
  chk_psr_drops: assert property ((sync_wr && !wdata_i[B_HOLD]) ##1 !we_i[*3]
    |=> !shared_prescaler_reset_o) else $error("shared reset did not clear");
  chk_unmapped_zero: assert property ($past(!mapped_a) |-> rdata_o == RST_BYTE)
    else $error("unmapped read not zero");
endmodule : atfpc_checker
////////////////////////////////////////////////////////////////
bind atfpc_timer atfpc_checker i_chk (.ref_clk_i, .rst_n_i, .addr_i, .wdata_i, .we_i,
  .rdata_o, .global_irq_en_i, .cmp_a_irq_o, .ovf_irq_o, .ext_buf_en_o, .xtal_run_o,
  .shared_prescaler_reset_o);

// >>> bench/tb_top.sv
/*
  self-checking bench for atfpc_timer: register reads and writes over the data-space
  port, timer events, prescaler-reset control and async busy tracking.
  assumes the checker is bound from its own file.
*/
`timescale 1ns/100ps
module tb_top
  import atfpc_pkg::*;
;
  localparam int DLY = 2;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic we_i = 1'b0;
  logic global_irq_en_i = 1'b0;
  logic cmp_a_vec_ack_i = 1'b0;
  logic ovf_vec_ack_i = 1'b0;
  logic osc_input_pin_i = 1'b0;
  wire [7:0] rdata_o;
  wire [7:0] counter_value_o;
  wire cmp_a_irq_o, ovf_irq_o, ext_buf_en_o, xtal_run_o, shared_prescaler_reset_o;
  int mismatches = 0;
  int checks_done = 0;
  localparam logic [7:0] RST_REGS [6] = '{OFF_SYNC, OFF_STATUS, OFF_FLAGS, OFF_MASK,
                                          OFF_COUNT, 8'h50};
  always #25 ref_clk_i = ~ref_clk_i;
  atfpc_timer i_dut (.ref_clk_i, .rst_n_i, .addr_i, .wdata_i, .we_i, .rdata_o,
    .global_irq_en_i, .cmp_a_vec_ack_i, .ovf_vec_ack_i, .osc_input_pin_i, .cmp_a_irq_o,
    .ovf_irq_o, .ext_buf_en_o, .xtal_run_o, .shared_prescaler_reset_o, .counter_value_o);
  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #DLY;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    we_i = 1'b1;
    addr_i = a;
    wdata_i = d;
    cyc(1);
    we_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    cyc(1);
    addr_i = a;
    cyc(1);
    check(what, rdata_o, exp);
  endtask : rd
  task automatic wait_irq(input bit ovf, input string what);
    int n;
    n = 0;
    while (((ovf ? ovf_irq_o : cmp_a_irq_o) !== 1'b1) && n < 600) begin
      cyc(1);
      n++;
    end
    check(what, {7'h00, n < 600}, 8'h01);
  endtask : wait_irq
  task automatic osc_pulse();
    cyc(1);
    osc_input_pin_i = 1'b1;
    cyc(2);
    osc_input_pin_i = 1'b0;
    cyc(4);
  endtask : osc_pulse
  ////////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    rst_n_i = 1'b1;
    foreach (RST_REGS[i]) rd(RST_REGS[i], 8'h00, "reset value");
    // compare and overflow in normal mode, counter write blocks the first match
    wr(OFF_CMP_A, 8'h20);
    wr(OFF_COUNT, 8'h20);
    wr(OFF_MASK, 8'h03);
    global_irq_en_i = 1'b1;
    wr(OFF_CTRL_B, 8'h01);
    cyc(4);
    rd(OFF_FLAGS, 8'h00, "flags after counter write");
    wait_irq(1'b1, "overflow request");
    wait_irq(1'b0, "compare request");
    wr(OFF_CTRL_B, 8'h00);
    rd(OFF_FLAGS, 8'h03, "both flags");
    wr(OFF_FLAGS, 8'h00);
    rd(OFF_FLAGS, 8'h03, "flags after zero write");
    global_irq_en_i = 1'b0;
    cyc(2);
    check("requests gated", {6'h00, cmp_a_irq_o, ovf_irq_o}, 8'h00);
    global_irq_en_i = 1'b1;
    wr(OFF_FLAGS, 8'h02);
    rd(OFF_FLAGS, 8'h01, "flags after compare clear");
    check("requests", {6'h00, cmp_a_irq_o, ovf_irq_o}, 8'h01);
    wr(OFF_MASK, 8'h02);
    check("request after mask clear", {7'h00, ovf_irq_o}, 8'h00);
    wr(OFF_MASK, 8'h03);
    check("request after mask set", {7'h00, ovf_irq_o}, 8'h01);
    ovf_vec_ack_i = 1'b1;
    cyc(1);
    ovf_vec_ack_i = 1'b0;
    rd(OFF_FLAGS, 8'h00, "flags after overflow vector");
    // phase correct: no overflow at the top, overflow on turning at zero
    wr(OFF_COUNT, 8'h30);
    wr(OFF_CTRL_A, 8'h01);
    wr(OFF_CTRL_B, 8'h01);
    cyc(240);
    rd(OFF_FLAGS, 8'h00, "flags past top");
    wait_irq(1'b1, "phase overflow request");
    check("counter at turn", {7'h00, counter_value_o <= 8'h01}, 8'h01);
    wr(OFF_CTRL_B, 8'h00);
    rd(OFF_FLAGS, 8'h03, "phase flags");
    cmp_a_vec_ack_i = 1'b1;
    cyc(1);
    cmp_a_vec_ack_i = 1'b0;
    wr(OFF_FLAGS, 8'h01);
    rd(OFF_FLAGS, 8'h00, "flags after vector and write");
    // prescaler reset and synchronisation mode
    wr(OFF_SYNC, 8'h81);
    cyc(3);
    rd(OFF_SYNC, 8'h81, "held shared reset");
    check("shared reset out", {7'h00, shared_prescaler_reset_o}, 8'h01);
    wr(OFF_SYNC, 8'h83);
    cyc(3);
    rd(OFF_SYNC, 8'h83, "held both resets");
    wr(OFF_SYNC, 8'h00);
    rd(OFF_SYNC, 8'h00, "released resets");
    wr(OFF_SYNC, 8'h01);
    cyc(3);
    rd(OFF_SYNC, 8'h00, "shared reset self clear");
    check("shared reset out", {7'h00, shared_prescaler_reset_o}, 8'h00);
    wr(OFF_SYNC, 8'h02);
    cyc(3);
    rd(OFF_SYNC, 8'h00, "async reset self clear");
    // clock source and async busy tracking
    wr(OFF_STATUS, 8'h40);
    cyc(3);
    check("buffer and crystal", {6'h00, ext_buf_en_o, xtal_run_o}, 8'h00);
    wr(OFF_STATUS, 8'h60);
    cyc(3);
    check("buffer and crystal", {6'h00, ext_buf_en_o, xtal_run_o}, 8'h02);
    wr(OFF_STATUS, 8'h20);
    cyc(3);
    check("buffer and crystal", {6'h00, ext_buf_en_o, xtal_run_o}, 8'h01);
    wr(OFF_CMP_A, 8'h33);
    cyc(2);
    rd(OFF_STATUS, 8'h28, "status one busy");
    wr(OFF_COUNT, 8'h44);
    wr(OFF_CMP_B, 8'h55);
    wr(OFF_CTRL_A, 8'h00);
    wr(OFF_CTRL_B, 8'h00);
    wr(OFF_SYNC, 8'h02);
    cyc(2);
    rd(OFF_STATUS, 8'h3F, "status all busy");
    rd(OFF_SYNC, 8'h02, "async reset waiting");
    osc_pulse();
    rd(OFF_STATUS, 8'h20, "status after transfer");
    rd(OFF_SYNC, 8'h00, "async reset done");
    rd(OFF_CMP_B, 8'h55, "compare b");
    rd(OFF_COUNT, 8'h44, "counter");
    wr(OFF_STATUS, 8'h00);
    rd(OFF_STATUS, 8'h00, "status cleared");
    give_verdict();
  end
  initial begin
    cyc(6000);
    mismatches++;
    give_verdict();
  end
endmodule : tb_top
